// File: verilog/cfhp_port.sv
// CPU-style parallel host port, one channel
//
// Functional notes
// [RL1] Select high: address and strobes ignored
// [RL2] Data-address read returns next received byte
// [RL3] Data-address write stores byte into transmit pipe
// [RL4] Status-address read drives status byte
// [RL5] Status bits: data available, suspend, configured
// [RL6] Status bit 1: transmit pipe has room
// [RL7] Status bits 4 to 7 undefined
// [RL8] Status-address write flushes pending transmit bytes
// [RL9] Send-immediate sampled on USB clock
// [RL10] Port active only when configuration selects it
// [RL11] Each channel instantiates its own port
// [RL12] Eight-bit bus driven only during read
// [RL13] Active-low strobes act on rising edge
`timescale 1ns/10ps
`include "cfhp_consts.svh"
module cfhp_port #(
  parameter int DEPTH = `CFHP_DEPTH
) (
  // Clock and reset (USB clock domain)
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mode from configuration memory
  input wire logic cpu_mode_en,
  // Processor pins
  input wire logic port_select_n,
  input wire logic register_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] parallel_data_bus_in,
  output logic [7:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe,
  // USB side receive pipe (source)
  input wire logic [7:0] usb_rx_data,
  input wire logic usb_rx_valid,
  output logic usb_rx_ready,
  // USB side transmit pipe (sink)
  output logic [7:0] usb_tx_data,
  output logic usb_tx_valid,
  input wire logic usb_tx_ready,
  output logic usb_tx_flush,
  // USB state
  input wire logic usb_suspend,
  input wire logic usb_configured
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cfhp_port: DEPTH must be a power of two >= 2");
  end

  localparam int AW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_in_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_in_n = rst_sync_q[1];

  logic [3:0] pin_s1_q, pin_s2_q;
  logic [7:0] bus_s1_q, bus_s2_q;
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      pin_s1_q <= 4'hF;
      pin_s2_q <= 4'hF;
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= {port_select_n, register_select, rd_n, wr_n};
      pin_s2_q <= pin_s1_q;
      bus_s1_q <= parallel_data_bus_in;
      bus_s2_q <= bus_s1_q;
    end
  end

  wire sel_n_s = pin_s2_q[3];
  wire addr_s = pin_s2_q[2];
  wire rd_n_s = pin_s2_q[1];
  wire wr_n_s = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Strobe edge detection
  wire access_ok = cpu_mode_en && !sel_n_s; // see [RL1] see [RL10]
  wire rd_active = access_ok && !rd_n_s;
  wire wr_active = access_ok && !wr_n_s;

  // Armed only by a selected low phase; a strobe seen while
  // deselected or out of mode does nothing when it rises
  logic rd_n_prev_q, wr_n_prev_q, rd_addr_q, wr_addr_q;
  logic rd_hit_q, wr_hit_q;
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      rd_n_prev_q <= 1'h1;
      wr_n_prev_q <= 1'h1;
      rd_addr_q <= 1'h0;
      wr_addr_q <= 1'h0;
      rd_hit_q <= 1'h0;
      wr_hit_q <= 1'h0;
    end else begin
      rd_n_prev_q <= rd_n_s;
      wr_n_prev_q <= wr_n_s;
      if (rd_active) rd_addr_q <= addr_s;
      if (wr_active) wr_addr_q <= addr_s;
      if (rd_active) rd_hit_q <= 1'h1; // see [RL1]
      else if (rd_n_s) rd_hit_q <= 1'h0;
      if (wr_active) wr_hit_q <= 1'h1; // see [RL1]
      else if (wr_n_s) wr_hit_q <= 1'h0;
    end
  end

  // Strobe completion on rising edge, address latched while low
  wire rd_rise = rd_n_s && !rd_n_prev_q && rd_hit_q // see [RL13]
    && cpu_mode_en;
  wire wr_rise = wr_n_s && !wr_n_prev_q && wr_hit_q // see [RL13]
    && cpu_mode_en;
  wire rd_data_done = rd_rise && rd_addr_q == `CFHP_SEL_DATA; // see [RL2]
  wire wr_data_done = wr_rise && wr_addr_q == `CFHP_SEL_DATA; // see [RL3]
  wire wr_stat_done = wr_rise && wr_addr_q == `CFHP_SEL_STATUS; // see [RL8]

  logic [7:0] wr_byte_q;
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) wr_byte_q <= 8'h00;
    else if (wr_active) wr_byte_q <= bus_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive pipe, private to this channel // see [RL11]
  logic [7:0] rx_mem [DEPTH];
  logic [AW:0] rx_wp_q, rx_rp_q;
  wire rx_empty = rx_wp_q == rx_rp_q;
  wire rx_full = rx_wp_q == {~rx_rp_q[AW], rx_rp_q[AW-1:0]};
  wire rx_push = usb_rx_valid && !rx_full;
  wire rx_pop = rd_data_done && !rx_empty; // see [RL2]
  always_ff @(posedge ref_clk) begin
    if (rx_push) rx_mem[rx_wp_q[AW-1:0]] <= usb_rx_data;
  end
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit pipe
  logic [7:0] tx_mem [DEPTH];
  logic [AW:0] tx_wp_q, tx_rp_q;
  wire tx_empty = tx_wp_q == tx_rp_q;
  wire tx_full = tx_wp_q == {~tx_rp_q[AW], tx_rp_q[AW-1:0]};
  wire tx_push = wr_data_done && !tx_full; // see [RL3]
  wire tx_pop = usb_tx_valid && usb_tx_ready;
  always_ff @(posedge ref_clk) begin
    if (tx_push) tx_mem[tx_wp_q[AW-1:0]] <= wr_byte_q;
  end
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status byte and bus drive
  cfhp_pkg::cfhp_status_type status;
  assign status.rx_data_available = !rx_empty; // see [RL5]
  assign status.tx_space_available = !tx_full; // see [RL6]
  assign status.suspend = usb_suspend; // see [RL5]
  assign status.configured = usb_configured; // see [RL5]
  wire [7:0] status_byte = {`CFHP_ST_UNUSED, status}; // see [RL7]
  wire [7:0] rd_mux = addr_s ? status_byte // see [RL4]
                             : rx_mem[rx_rp_q[AW-1:0]];

  logic [7:0] bus_out_q;
  logic bus_oe_q;
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      bus_out_q <= 8'h00;
      bus_oe_q <= 1'h0;
    end else begin
      bus_oe_q <= rd_active; // see [RL12]
      if (rd_active) bus_out_q <= rd_mux;
    end
  end
  assign parallel_data_bus_out = bus_out_q;
  assign parallel_data_bus_oe = bus_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // USB-side outputs and send-immediate
  logic flush_q, rx_ready_q, tx_valid_q;
  logic [7:0] tx_data_q;
  always_ff @(posedge ref_clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      flush_q <= 1'h0;
      rx_ready_q <= 1'h0;
      tx_valid_q <= 1'h0;
      tx_data_q <= 8'h00;
    end else begin
      flush_q <= wr_stat_done; // see [RL8] see [RL9]
      rx_ready_q <= !(rx_full || (rx_push && rx_wp_q + 1'b1 ==
                    {~rx_rp_q[AW], rx_rp_q[AW-1:0]}));
      tx_valid_q <= 1'h0;
      tx_data_q <= tx_mem[tx_rp_q[AW-1:0]];
      if (!tx_empty && !tx_pop) tx_valid_q <= 1'h1;
    end
  end
  assign usb_rx_ready = rx_ready_q;
  assign usb_tx_valid = tx_valid_q;
  assign usb_tx_data = tx_data_q;
  assign usb_tx_flush = flush_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wr_stat;
    wr_stat_done;
  endsequence
  sequence s_rd_stat;
    rd_active && addr_s;
  endsequence
  sequence s_tx_stall;
    usb_tx_valid && !usb_tx_ready;
  endsequence
  AST_FLUSH: assert property ( // see [RL8]
    @(posedge ref_clk) disable iff (!rst_in_n)
    s_wr_stat |=> usb_tx_flush)
    else $error("flush missing after status write");
  AST_NO_FLUSH: assert property ( // see [RL9]
    @(posedge ref_clk) disable iff (!rst_in_n)
    !wr_stat_done |=> !usb_tx_flush)
    else $error("spurious flush");
  AST_FLUSH_PULSE: assert property ( // see [RL8]
    @(posedge ref_clk) disable iff (!rst_in_n)
    usb_tx_flush |=> !usb_tx_flush)
    else $error("flush longer than one cycle");
  AST_STAT_NOPUSH: assert property ( // see [RL8]
    @(posedge ref_clk) disable iff (!rst_in_n)
    s_wr_stat |-> !tx_push)
    else $error("status write stored a byte");
  AST_OE_RD: assert property ( // see [RL12]
    @(posedge ref_clk) disable iff (!rst_in_n)
    parallel_data_bus_oe |-> $past(rd_active))
    else $error("bus driven outside read");
  AST_OE_HOLD: assert property ( // see [RL12]
    @(posedge ref_clk) disable iff (!rst_in_n)
    rd_active |=> parallel_data_bus_oe)
    else $error("bus not driven during read");
  AST_DESEL: assert property ( // see [RL1]
    @(posedge ref_clk) disable iff (!rst_in_n)
    sel_n_s |=> !parallel_data_bus_oe)
    else $error("bus driven while deselected");
  AST_DESEL_RD: assert property ( // see [RL1]
    @(posedge ref_clk) disable iff (!rst_in_n)
    sel_n_s && !rd_hit_q |=> !rd_hit_q)
    else $error("read armed while deselected");
  AST_DESEL_WR: assert property ( // see [RL1]
    @(posedge ref_clk) disable iff (!rst_in_n)
    sel_n_s && !wr_hit_q |=> !wr_hit_q)
    else $error("write armed while deselected");
  AST_MODE: assert property ( // see [RL10]
    @(posedge ref_clk) disable iff (!rst_in_n)
    !cpu_mode_en |-> !tx_push && !rx_pop)
    else $error("access while mode off");
  AST_MODE_OE: assert property ( // see [RL10]
    @(posedge ref_clk) disable iff (!rst_in_n)
    !cpu_mode_en |=> !parallel_data_bus_oe)
    else $error("bus driven while mode off");
  AST_STAT: assert property ( // see [RL4]
    @(posedge ref_clk) disable iff (!rst_in_n)
    s_rd_stat |=> parallel_data_bus_out[3:0] == $past(status))
    else $error("status byte wrong");
  AST_STAT_HI: assert property ( // see [RL7]
    @(posedge ref_clk) disable iff (!rst_in_n)
    s_rd_stat |=> parallel_data_bus_out[7:4] == `CFHP_ST_UNUSED)
    else $error("status upper bits wrong");
  AST_RX_POP: assert property ( // see [RL2]
    @(posedge ref_clk) disable iff (!rst_in_n)
    rx_pop |=> rx_rp_q == $past(rx_rp_q) + 1'b1)
    else $error("receive pointer did not advance");
  AST_RX_STABLE: assert property ( // see [RL2]
    @(posedge ref_clk) disable iff (!rst_in_n)
    !rx_pop |=> rx_rp_q == $past(rx_rp_q))
    else $error("receive pointer moved without read");
  AST_RX_FULL: assert property ( // see [RL2]
    @(posedge ref_clk) disable iff (!rst_in_n)
    rx_full |=> !usb_rx_ready)
    else $error("receive ready while full");
  AST_TX_PUSH: assert property ( // see [RL3]
    @(posedge ref_clk) disable iff (!rst_in_n)
    tx_push |=> tx_wp_q == $past(tx_wp_q) + 1'b1)
    else $error("transmit pointer did not advance");
  AST_TX_STABLE: assert property ( // see [RL3]
    @(posedge ref_clk) disable iff (!rst_in_n)
    !tx_push |=> tx_wp_q == $past(tx_wp_q))
    else $error("transmit pointer moved without write");
  AST_TX_HOLD: assert property ( // see [RL3]
    @(posedge ref_clk) disable iff (!rst_in_n)
    s_tx_stall |=> usb_tx_valid && $stable(usb_tx_data))
    else $error("transmit byte dropped while stalled");
  AST_TX_GAP: assert property ( // see [RL3]
    @(posedge ref_clk) disable iff (!rst_in_n)
    tx_pop |=> !usb_tx_valid)
    else $error("transmit valid held after pop");
  AST_SPACE: assert property ( // see [RL6]
    @(posedge ref_clk) disable iff (!rst_in_n)
    tx_full |-> !status_byte[`CFHP_ST_TXSP])
    else $error("space shown while full");

endmodule : cfhp_port

// File: verilog/cfhp_consts.svh
// Constants for the CPU-style parallel host port
`ifndef CFHP_CONSTS_SVH
`define CFHP_CONSTS_SVH
`define CFHP_DATA_W 8
`define CFHP_SEL_DATA 1'h0
`define CFHP_SEL_STATUS 1'h1
`define CFHP_ST_RXAV 0
`define CFHP_ST_TXSP 1
`define CFHP_ST_SUSP 2
`define CFHP_ST_CONF 3
`define CFHP_ST_UNUSED 4'h0
`define CFHP_DEPTH 16
`endif

// File: verilog/cfhp_pkg.sv
// Types for the CPU-style parallel host port
package cfhp_pkg;
  typedef struct packed {
    logic configured;
    logic suspend;
    logic tx_space_available;
    logic rx_data_available;
  } cfhp_status_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cfhp_byte_type;
endpackage : cfhp_pkg

// File: tb/cfhp_cpu_model.sv
// Processor bus master model for the host port
`timescale 1ns/10ps
module cfhp_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Processor pins
  output logic port_select_n,
  output logic register_select,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe
);
  logic drive;
  logic [7:0] wdata;
  ////////////////////////////////////////////////////////////////////////////
  // Wire level: device, processor, else pull-up
  assign bus_in = bus_oe ? bus_out : (drive ? wdata : 8'hFF);
  initial begin
    port_select_n = 1'h1;
    register_select = 1'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
    drive = 1'h0;
    wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One strobe: low four edges, then high with address held
  task automatic access(input logic sel_n, input logic rs, input logic wr,
    input logic [7:0] wd, output logic [7:0] rdat, output logic oe);
    @(posedge ref_clk);
    port_select_n <= sel_n;
    register_select <= rs;
    drive <= wr;
    wdata <= wd;
    @(posedge ref_clk);
    rd_n <= wr;
    wr_n <= ~wr;
    repeat (4) @(posedge ref_clk);
    rdat = bus_in;
    oe = bus_oe;
    rd_n <= 1'h1;
    wr_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    port_select_n <= 1'h1;
    drive <= 1'h0;
  endtask : access
endmodule : cfhp_cpu_model

// File: tb/cfhp_port_test.sv
// Self-checking bench for the host port
`timescale 1ns/10ps
`include "cfhp_consts.svh"
module cfhp_port_test;
  logic ref_clk, rst_n, cpu_mode_en, usb_rx_valid, usb_tx_ready;
  logic usb_suspend, usb_configured, sel_n, rsel, rd_n, wr_n, bus_oe;
  logic usb_rx_ready, usb_tx_valid, usb_tx_flush, oe;
  logic [7:0] usb_rx_data, bus_in, bus_out, usb_tx_data, rd;
  int err_count, checks_done, flushes, f0;
  cfhp_port #(.DEPTH(`CFHP_DEPTH)) i_cfhp_port (.ref_clk(ref_clk),
    .rst_n(rst_n), .cpu_mode_en(cpu_mode_en), .port_select_n(sel_n),
    .register_select(rsel), .rd_n(rd_n), .wr_n(wr_n),
    .parallel_data_bus_in(bus_in), .parallel_data_bus_out(bus_out),
    .parallel_data_bus_oe(bus_oe), .usb_rx_data(usb_rx_data),
    .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready),
    .usb_tx_data(usb_tx_data), .usb_tx_valid(usb_tx_valid),
    .usb_tx_ready(usb_tx_ready), .usb_tx_flush(usb_tx_flush),
    .usb_suspend(usb_suspend), .usb_configured(usb_configured));
  cfhp_cpu_model i_cfhp_cpu_model (.ref_clk(ref_clk),
    .port_select_n(sel_n), .register_select(rsel), .rd_n(rd_n),
    .wr_n(wr_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: byte %h not %h", $time, got, exp);
    end
  endtask : check8
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : check1
  task automatic rd_chk(input logic rs, input logic [7:0] exp,
    input logic [7:0] mask);
    i_cfhp_cpu_model.access(1'h0, rs, 1'h0, 8'h00, rd, oe);
    check8(rd & mask, exp);
    check1(oe, 1'h1);
  endtask : rd_chk
  task automatic wr(input logic rs, input logic [7:0] d);
    i_cfhp_cpu_model.access(1'h0, rs, 1'h1, d, rd, oe);
  endtask : wr
  task automatic rx_push(input logic [7:0] d);
    @(posedge ref_clk);
    usb_rx_data <= d;
    usb_rx_valid <= 1'h1;
    do @(posedge ref_clk); while (usb_rx_ready !== 1'h1);
    usb_rx_valid <= 1'h0;
  endtask : rx_push
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (usb_tx_flush === 1'h1) flushes++;
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    $display("unexpected at %0t: run hung", $time);
    test_done;
  end
  initial begin
    {rst_n, usb_rx_valid, usb_tx_ready, usb_suspend, usb_configured} = 0;
    {err_count, checks_done, flushes} = 0;
    cpu_mode_en = 1'h1;
    usb_rx_data = 8'h00;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (5) @(posedge ref_clk);
    check1(usb_rx_ready, 1'h1);
    for (int i = 0; i < 4; i++) begin
      usb_suspend <= i[0];
      usb_configured <= i[1];
      rd_chk(1'h1, {4'h0, i[1], i[0], 2'h2}, 8'h0F);
    end
    {usb_suspend, usb_configured} <= 2'h0;
    $display("test status done");
    rx_push(8'hA5);
    rx_push(8'h3C);
    rd_chk(1'h1, 8'h03, 8'h0F);
    rd_chk(1'h0, 8'hA5, 8'hFF);
    rd_chk(1'h0, 8'h3C, 8'hFF);
    rd_chk(1'h1, 8'h02, 8'h0F);
    $display("test receive done");
    rx_push(8'h77);
    i_cfhp_cpu_model.access(1'h1, 1'h0, 1'h0, 8'h00, rd, oe);
    check1(oe, 1'h0);
    i_cfhp_cpu_model.access(1'h1, 1'h0, 1'h1, 8'h11, rd, oe);
    cpu_mode_en <= 1'h0;
    wr(1'h0, 8'h22);
    repeat (3) @(posedge ref_clk);
    check1(usb_tx_valid, 1'h0);
    cpu_mode_en <= 1'h1;
    rd_chk(1'h0, 8'h77, 8'hFF);
    $display("test ignored done");
    wr(1'h0, 8'h5A);
    repeat (3) @(posedge ref_clk);
    check1(usb_tx_valid, 1'h1);
    check8(usb_tx_data, 8'h5A);
    f0 = flushes;
    wr(1'h1, 8'h00);
    repeat (2) @(posedge ref_clk);
    check8(8'(flushes - f0), 8'h01);
    for (int i = 1; i < `CFHP_DEPTH; i++) wr(1'h0, 8'(i));
    rd_chk(1'h1, 8'h00, 8'h0F);
    wr(1'h0, 8'hEE);
    usb_tx_ready <= 1'h1;
    for (int j = 0; j < `CFHP_DEPTH; j++) begin
      do @(posedge ref_clk); while (usb_tx_valid !== 1'h1);
      check8(usb_tx_data, (j == 0) ? 8'h5A : 8'(j));
    end
    repeat (6) @(posedge ref_clk);
    check1(usb_tx_valid, 1'h0);
    $display("test transmit done");
    test_done;
  end
endmodule : cfhp_port_test
